// [verilog/mrsi_pkg.sv]
`default_nettype none
package mrsi_pkg;
  // Bit symbols exchanged with the link layer
  localparam logic BIT_ZERO = 1'h0;
  localparam logic BIT_ONE = 1'h1;
  // Half-bit line levels
  localparam logic LEVEL_LOW = 1'h0;
  localparam logic LEVEL_HIGH = 1'h1;
  // Unchanged half-bit symbols tolerated before carrier is lost
  localparam logic [2:0] CARRIER_IDLE_LIMIT = 3'h3;
  // Decoded bits remembered for the alternation check
  localparam logic [1:0] SYNC_HISTORY = 2'h2;
  localparam logic [2:0] SYNC_PATTERN_A = 3'h2;
  localparam logic [2:0] SYNC_PATTERN_B = 3'h5;
  // Transmit half-bit timing
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int HALF_BIT_NS = 500;
  localparam int HALF_BIT_CYCLES = (HALF_BIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int TX_FIFO_DEPTH = 16;
  localparam int TX_FIFO_WIDTH = 1;

  typedef struct packed {
    logic carrier;
    logic decode_error;
    logic sync;
  } mrsi_status_t;

  localparam mrsi_status_t STATUS_RESET = '{carrier: 1'h0, decode_error: 1'h0, sync: 1'h0};

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_FIRST,
    TX_SECOND
  } mrsi_tx_state_t;
endpackage
`default_nettype wire

// [verilog/mrsi_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
module mrsi_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_INDEX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_INDEX) ? '0 : wr_ptr + AW'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_INDEX) ? '0 : rd_ptr + AW'(1);
    end
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [verilog/mrsi_core.sv]
`timescale 1ns/1ns
`default_nettype none
module mrsi_core
  import mrsi_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_BIT_CYCLES,
  parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic half_bit_level,
  input wire logic half_bit_strobe,
  output mrsi_status_t status,
  output mrsi_status_t indication,
  output logic bit_transfer,
  output logic bit_transfer_valid,
  input wire logic link_bit,
  input wire logic link_bit_valid,
  output logic link_bit_ready,
  output logic tx_half_bit_level,
  output logic tx_enable_n,
  output logic tx_busy
);
  localparam logic [15:0] HALF_LAST = 16'(HALF_CYCLES - 1);

  // Receive state
  mrsi_status_t next_status, next_indication;
  logic prev_level, next_prev_level;
  logic have_level, next_have_level;
  logic [2:0] same_count, next_same_count;
  logic phase, next_phase;
  logic first_level, next_first_level;
  logic [1:0] hist, next_hist;
  logic [1:0] hist_cnt, next_hist_cnt;
  logic next_bit_transfer, next_bit_transfer_valid;
  logic changed, dec_valid, pair_bad;

  assign changed = half_bit_strobe && have_level && (half_bit_level != prev_level);

  always_comb begin
    next_status = status;
    next_prev_level = prev_level;
    next_have_level = have_level;
    next_same_count = same_count;
    next_phase = phase;
    next_first_level = first_level;
    next_hist = hist;
    next_hist_cnt = hist_cnt;
    next_bit_transfer = bit_transfer;
    next_bit_transfer_valid = 1'h0;
    dec_valid = 1'h0;
    pair_bad = 1'h0;
    if (half_bit_strobe) begin
      next_prev_level = half_bit_level;
      next_have_level = 1'h1;
      if (changed) begin
        next_same_count = '0;
        next_status.carrier = 1'h1;
      end else if (have_level && same_count != CARRIER_IDLE_LIMIT) begin
        next_same_count = same_count + 3'h1;
      end
      if (!status.carrier) begin
        // The edge that wakes carrier marks a mid-cell, so it is a whole pair
        next_phase = 1'h0;
        dec_valid = changed;
      end else if (!changed && same_count == CARRIER_IDLE_LIMIT) begin
        next_status.carrier = 1'h0;
        next_status.sync = 1'h0;
        next_hist_cnt = '0;
        next_phase = 1'h0;
      end else if (!phase) begin
        next_first_level = half_bit_level;
        next_phase = 1'h1;
      end else if (first_level != half_bit_level) begin
        dec_valid = 1'h1;
        next_phase = 1'h0;
      end else begin
        // Slip one half-bit to regain cell alignment
        pair_bad = 1'h1;
        next_first_level = half_bit_level;
      end
    end
    if (dec_valid) begin
      next_status.decode_error = 1'h0;
      if (status.sync) begin
        next_bit_transfer = (half_bit_level == LEVEL_HIGH) ? BIT_ONE : BIT_ZERO;
        next_bit_transfer_valid = 1'h1;
      end
      if (hist_cnt == SYNC_HISTORY && ({hist, half_bit_level} == SYNC_PATTERN_A ||
          {hist, half_bit_level} == SYNC_PATTERN_B)) begin
        next_status.sync = 1'h1;
      end
      next_hist = {hist[0], half_bit_level};
      if (hist_cnt != SYNC_HISTORY) begin
        next_hist_cnt = hist_cnt + 2'h1;
      end
    end
    if (pair_bad) begin
      next_status.decode_error = 1'h1;
      next_hist_cnt = '0;
    end
    next_indication = next_status ^ status;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status <= STATUS_RESET;
      indication <= STATUS_RESET;
      prev_level <= LEVEL_LOW;
      have_level <= 1'h0;
      same_count <= '0;
      phase <= 1'h0;
      first_level <= LEVEL_LOW;
      hist <= '0;
      hist_cnt <= '0;
      bit_transfer <= BIT_ZERO;
      bit_transfer_valid <= 1'h0;
    end else begin
      status <= next_status;
      indication <= next_indication;
      prev_level <= next_prev_level;
      have_level <= next_have_level;
      same_count <= next_same_count;
      phase <= next_phase;
      first_level <= next_first_level;
      hist <= next_hist;
      hist_cnt <= next_hist_cnt;
      bit_transfer <= next_bit_transfer;
      bit_transfer_valid <= next_bit_transfer_valid;
    end
  end

  // Transmit path: requests queue so the link layer can run ahead of the line
  logic fifo_valid, fifo_bit, fifo_pop;
  mrsi_tx_state_t tx_state, next_tx_state;
  logic [15:0] half_cnt, next_half_cnt;
  logic tx_bit, next_tx_bit;
  logic next_tx_half_bit_level;

  mrsi_fifo #(
    .WIDTH(TX_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(link_bit_valid),
    .in_ready(link_bit_ready),
    .in_data(link_bit),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_bit)
  );

  assign fifo_pop = fifo_valid && (tx_state == TX_IDLE ||
                    (tx_state == TX_SECOND && half_cnt == HALF_LAST));

  always_comb begin
    next_tx_state = tx_state;
    next_half_cnt = half_cnt;
    next_tx_bit = tx_bit;
    next_tx_half_bit_level = tx_half_bit_level;
    if (fifo_pop) begin
      next_tx_state = TX_FIRST;
      next_half_cnt = '0;
      next_tx_bit = fifo_bit;
      next_tx_half_bit_level = (fifo_bit == BIT_ONE) ? LEVEL_LOW : LEVEL_HIGH;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          next_half_cnt = '0;
        end
        TX_FIRST: begin
          if (half_cnt == HALF_LAST) begin
            next_tx_state = TX_SECOND;
            next_half_cnt = '0;
            next_tx_half_bit_level = (tx_bit == BIT_ONE) ? LEVEL_HIGH : LEVEL_LOW;
          end else begin
            next_half_cnt = half_cnt + 16'h1;
          end
        end
        TX_SECOND: begin
          if (half_cnt == HALF_LAST) begin
            next_tx_state = TX_IDLE;
            next_half_cnt = '0;
          end else begin
            next_half_cnt = half_cnt + 16'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_state <= TX_IDLE;
      half_cnt <= '0;
      tx_bit <= BIT_ZERO;
      tx_half_bit_level <= LEVEL_LOW;
    end else begin
      tx_state <= next_tx_state;
      half_cnt <= next_half_cnt;
      tx_bit <= next_tx_bit;
      tx_half_bit_level <= next_tx_half_bit_level;
    end
  end

  assign tx_busy = (tx_state != TX_IDLE);
  // Line driver enabled only while a cell is being sent
  assign tx_enable_n = (tx_state == TX_IDLE);

  // Checks
  sequence s_idle_run;
    half_bit_strobe && !changed && status.carrier && same_count == CARRIER_IDLE_LIMIT;
  endsequence

  sequence s_first_half_end;
    tx_state == TX_FIRST && half_cnt == HALF_LAST;
  endsequence

  a_carrier_on_change: assert property (@(posedge clock) disable iff (!rstn)
    changed |=> status.carrier) else $error("carrier not raised on level change");

  a_carrier_off_idle: assert property (@(posedge clock) disable iff (!rstn)
    s_idle_run |=> !status.carrier && !status.sync)
    else $error("carrier or sync held after idle run");

  a_carrier_stays_on: assert property (@(posedge clock) disable iff (!rstn)
    status.carrier && same_count < CARRIER_IDLE_LIMIT |=> status.carrier)
    else $error("carrier dropped too early");

  a_carrier_ind_edge: assert property (@(posedge clock) disable iff (!rstn)
    ##1 indication.carrier == (status.carrier != $past(status.carrier)))
    else $error("carrier indication not tied to change");

  a_error_ind_edge: assert property (@(posedge clock) disable iff (!rstn)
    ##1 indication.decode_error == (status.decode_error != $past(status.decode_error)))
    else $error("error indication not tied to change");

  a_sync_ind_edge: assert property (@(posedge clock) disable iff (!rstn)
    ##1 indication.sync == (status.sync != $past(status.sync)))
    else $error("sync indication not tied to change");

  a_pair_valid_clear: assert property (@(posedge clock) disable iff (!rstn)
    dec_valid |=> !status.decode_error) else $error("valid pair left error set");

  a_pair_bad_error: assert property (@(posedge clock) disable iff (!rstn)
    half_bit_strobe && status.carrier && phase && !changed && first_level == half_bit_level
    && same_count != CARRIER_IDLE_LIMIT |=> status.decode_error)
    else $error("violation not flagged");

  a_sync_drop_carrier: assert property (@(posedge clock) disable iff (!rstn)
    !status.carrier |-> !status.sync) else $error("sync without carrier");

  a_deliver_when_sync: assert property (@(posedge clock) disable iff (!rstn)
    bit_transfer_valid |-> $past(status.sync) && status.sync)
    else $error("bit delivered while not synchronised");

  a_tx_opposite_half: assert property (@(posedge clock) disable iff (!rstn)
    s_first_half_end |=> tx_state == TX_SECOND && tx_half_bit_level != $past(tx_half_bit_level))
    else $error("transmit halves not opposite");

  a_reset_quiet: assert property (@(posedge clock) disable iff (!rstn)
    !have_level |-> status == STATUS_RESET && indication == STATUS_RESET)
    else $error("status active before any symbol");
endmodule
`default_nettype wire

// [tb/mrsi_link_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mrsi_link_model (
  input wire logic clock,
  input wire logic rstn,
  output logic link_bit,
  output logic link_bit_valid,
  input wire logic link_bit_ready,
  input wire logic bit_transfer,
  input wire logic bit_transfer_valid
);
  // Queues are loaded and read by the bench between transfers
  logic tx_q[$];
  logic rx_q[$];
  int stall_cnt;
  initial begin
    link_bit = 1'h0;
    link_bit_valid = 1'h0;
    stall_cnt = 0;
  end
  // Request held unchanged until the edge that takes it
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_bit_valid <= 1'h0;
    end else begin
      if (link_bit_valid && link_bit_ready) begin
        tx_q.delete(0);
      end
      if (link_bit_valid && !link_bit_ready) begin
        stall_cnt++;
      end
      if (tx_q.size() > 0) begin
        link_bit <= tx_q[0];
        link_bit_valid <= 1'h1;
      end else begin
        link_bit_valid <= 1'h0;
      end
    end
  end
  // No back-pressure on delivery, so every pulse is taken
  always @(posedge clock) begin
    if (rstn && bit_transfer_valid === 1'h1) begin
      rx_q.push_back(bit_transfer);
    end
  end
endmodule
`default_nettype wire

// [tb/mrsi_core_test.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) check_val(a, e)
module mrsi_core_test;
  import mrsi_pkg::*;
  localparam int HC = 2;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic half_bit_level = 1'h0;
  logic half_bit_strobe = 1'h0;
  mrsi_status_t status;
  mrsi_status_t indication;
  logic bit_transfer, bit_transfer_valid;
  logic link_bit, link_bit_valid, link_bit_ready;
  logic tx_half_bit_level, tx_enable_n, tx_busy;
  int error_cnt = 0;
  int tests_run = 0;
  int ind_c = 0;
  int ind_e = 0;
  int ind_s = 0;
  logic line_q[$];
  always #25 clock = ~clock;
  mrsi_core #(.HALF_CYCLES(HC), .FIFO_DEPTH(16)) uut (.clock(clock), .rstn(rstn),
    .half_bit_level(half_bit_level), .half_bit_strobe(half_bit_strobe), .status(status),
    .indication(indication), .bit_transfer(bit_transfer),
    .bit_transfer_valid(bit_transfer_valid), .link_bit(link_bit),
    .link_bit_valid(link_bit_valid), .link_bit_ready(link_bit_ready),
    .tx_half_bit_level(tx_half_bit_level), .tx_enable_n(tx_enable_n), .tx_busy(tx_busy));
  mrsi_link_model link (.clock(clock), .rstn(rstn), .link_bit(link_bit),
    .link_bit_valid(link_bit_valid), .link_bit_ready(link_bit_ready),
    .bit_transfer(bit_transfer), .bit_transfer_valid(bit_transfer_valid));
  always @(posedge clock) begin
    if (rstn) begin
      ind_c += (indication.carrier === 1'h1);
      ind_e += (indication.decode_error === 1'h1);
      ind_s += (indication.sync === 1'h1);
      if (tx_enable_n === 1'h0) line_q.push_back(tx_half_bit_level);
    end
  end
  task automatic check_val(input logic [15:0] a, input logic [15:0] e);
    tests_run++;
    if (a !== e) begin
      $display("[ERR] t=%0t got %h exp %h", $time, a, e);
      error_cnt++;
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic half(input logic lvl);
    @(posedge clock);
    half_bit_strobe <= 1'h1;
    half_bit_level <= lvl;
    @(posedge clock);
    half_bit_strobe <= 1'h0;
  endtask
  task automatic send_bit(input logic b);
    half(~b);
    half(b);
  endtask
  task automatic settle();
    @(posedge clock);
    #1;
  endtask
  task automatic t_reset();
    `CHK(status, STATUS_RESET);
    `CHK({tx_enable_n, tx_busy, link_bit_ready}, 3'h5);
  endtask
  task automatic t_sync_and_deliver();
    half(LEVEL_LOW);
    settle();
    `CHK(16'(ind_c + ind_e + ind_s), 16'h0);
    half(LEVEL_HIGH);
    settle();
    `CHK(status, 3'h4);
    send_bit(BIT_ZERO);
    send_bit(BIT_ONE);
    settle();
    `CHK(status, 3'h5);
    `CHK(16'(link.rx_q.size()), 16'h0);
    send_bit(1'h1);
    send_bit(1'h0);
    send_bit(1'h0);
    send_bit(1'h1);
    settle();
    `CHK({link.rx_q[0], link.rx_q[1], link.rx_q[2], link.rx_q[3]}, 4'h9);
    `CHK(16'(link.rx_q.size()), 16'h4);
    `CHK(16'({4'(ind_c), 4'(ind_e), 4'(ind_s)}), 16'h101);
  endtask
  task automatic t_error();
    half(LEVEL_LOW);
    half(LEVEL_LOW);
    settle();
    `CHK(status, 3'h7);
    half(LEVEL_HIGH);
    settle();
    `CHK(status, 3'h5);
    `CHK(16'(ind_e), 16'h2);
  endtask
  task automatic t_carrier_off();
    // Three unchanged halves keep carrier on, but an equal pair is a violation
    for (int i = 0; i < 3; i++) half(LEVEL_HIGH);
    settle();
    `CHK(status, 3'h7);
    half(LEVEL_HIGH);
    settle();
    // Carrier loss leaves the error flag alone
    `CHK(status, 3'h2);
    `CHK(16'(ind_c), 16'h2);
    `CHK(16'(ind_s), 16'h2);
    `CHK(16'(ind_e), 16'h3);
  endtask
  task automatic t_transmit();
    int n;
    n = 0;
    // Twenty-four bits outrun the 16-deep queue, so requests must stall
    for (int i = 0; i < 24; i++) link.tx_q.push_back(logic'(i % 3 == 0));
    while (line_q.size() < 96 && n < 1000) begin
      settle();
      n++;
    end
    repeat (3) settle();
    `CHK(16'(line_q.size()), 16'h60);
    for (int i = 0; i < 96; i++) begin
      `CHK(line_q[i], (i % 4 < 2) ^ ((i / 4) % 3 == 0));
    end
    `CHK(16'(link.stall_cnt > 0), 16'h1);
    `CHK({tx_busy, tx_enable_n}, 2'h1);
  endtask
  initial begin
    #(50 * 20000);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'h1;
    settle();
    t_reset();
    t_sync_and_deliver();
    t_error();
    t_carrier_off();
    t_transmit();
    conclude();
  end
endmodule
`default_nettype wire
